// ### hw/asrc_host.v
/*
  Host controller for a 256K x 16 asynchronous static memory. Takes one
  read or write request at a time and sequences the memory pins from
  flip-flops. Assumes the memory is wired directly to the pins and that
  the board resolves the data lines from the output enable.
  Pin timing is counted in whole clock cycles, so a faster clock needs
  larger cycle counts in the constants header. A write request with no
  lane selected still strobes the memory but stores nothing.
*/
`timescale 1ns/1ps
`include "asrc_consts.vh"

// Summary of operation
// - write strobe low means write, high means read, while selected
// - lane selects gate low byte and high byte independently
// - write spans overlap of chip select and write strobe low
// - address held stable at least 8 ns before write end, oe high
// - write strobe low at least 8 ns with oe high, 10 with oe low
// - chip select low at least 8 ns before write end
// - lane selects low at least 8 ns before write end
// - read address valid no later than chip select going low
module asrc_host #(
  parameter ADDR_W = `ASRC_ADDR_W,
  parameter DATA_W = `ASRC_DATA_W
) (
  input  wire              SYS_CLK,
  input  wire              RESET,
  input  wire              REQ_VALID,
  input  wire              REQ_WRITE,
  input  wire [ADDR_W-1:0] REQ_ADDR,
  input  wire [DATA_W-1:0] REQ_WDATA,
  input  wire [1:0]        REQ_LANES,
  output reg               REQ_READY,
  output reg               RSP_VALID,
  output reg  [DATA_W-1:0] RSP_RDATA,
  output reg  [ADDR_W-1:0] WORD_ADDR,
  output reg               CHIP_SEL_N,
  output reg               WRITE_N,
  output reg               OUT_EN_N,
  output reg               LOW_LANE_SEL_N,
  output reg               HIGH_LANE_SEL_N,
  input  wire [DATA_W-1:0] DATA_LINES_IN,
  output reg  [DATA_W-1:0] DATA_LINES_OUT,
  output reg               DATA_LINES_OE
);
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WSET  = 3'h1;
  localparam [2:0] ST_WPUL  = 3'h2;
  localparam [2:0] ST_WEND  = 3'h3;
  localparam [2:0] ST_RSET  = 3'h4;
  localparam [2:0] ST_RACC  = 3'h5;
  localparam [3:0] WP_CYC   = `ASRC_WP_CYC;
  localparam [3:0] ACC_CYC  = `ASRC_ACC_CYC;
  localparam       LW       = `ASRC_LANE_W;

  reg  [2:0] state_ff;
  reg  [2:0] nxt_state;
  reg        cnt_load;
  reg  [3:0] cnt_val;
  wire       cnt_done;
  reg  [1:0] lanes_ff;
  wire       take;
  wire [DATA_W-1:0] lane_rdata;

  asrc_hold_cnt #(.W(4)) asrc_hold_cnt_inst (
    .SYS_CLK  (SYS_CLK),
    .RESET    (RESET),
    .load     (cnt_load),
    .load_val (cnt_val),
    .done     (cnt_done)
  );

  // a request is taken only on an edge where both sides agree
  assign take = REQ_VALID && REQ_READY;

  // unread lane reads back as zero
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_lane
      assign lane_rdata[gi*LW +: LW] = lanes_ff[gi] ? DATA_LINES_IN[gi*LW +: LW] : {LW{1'b0}};
    end
  endgenerate

  always @* begin
    nxt_state = state_ff;
    cnt_load  = 1'b0;
    cnt_val   = 4'h0;
    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_state = REQ_WRITE ? ST_WSET : ST_RSET;
        end
      end
      ST_WSET: begin
        nxt_state = ST_WPUL;
        cnt_load  = 1'b1;
        cnt_val   = WP_CYC - 4'h1;
      end
      ST_WPUL: begin
        if (cnt_done) begin
          nxt_state = ST_WEND;
        end
      end
      ST_WEND: begin
        nxt_state = ST_IDLE;
      end
      ST_RSET: begin
        nxt_state = ST_RACC;
        cnt_load  = 1'b1;
        cnt_val   = ACC_CYC - 4'h1;
      end
      ST_RACC: begin
        if (cnt_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      state_ff        <= ST_IDLE;
      REQ_READY       <= 1'b0;
      RSP_VALID       <= 1'b0;
      RSP_RDATA       <= {DATA_W{1'b0}};
      WORD_ADDR       <= {ADDR_W{1'b0}};
      CHIP_SEL_N      <= 1'b1;
      WRITE_N         <= 1'b1;
      OUT_EN_N        <= 1'b1;
      LOW_LANE_SEL_N  <= 1'b1;
      HIGH_LANE_SEL_N <= 1'b1;
      DATA_LINES_OUT  <= {DATA_W{1'b0}};
      DATA_LINES_OE   <= 1'b0;
      lanes_ff        <= 2'h0;
    end else begin
      state_ff  <= nxt_state;
      RSP_VALID <= 1'b0;
      // dropped in the take cycle so a request still held is not taken twice
      REQ_READY <= (nxt_state == ST_IDLE) && !(state_ff == ST_IDLE && take);
      case (state_ff)
        ST_IDLE: begin
          CHIP_SEL_N      <= 1'b1;
          WRITE_N         <= 1'b1;
          OUT_EN_N        <= 1'b1;
          LOW_LANE_SEL_N  <= 1'b1;
          HIGH_LANE_SEL_N <= 1'b1;
          DATA_LINES_OE   <= 1'b0;
          if (take) begin
            WORD_ADDR      <= REQ_ADDR;
            lanes_ff       <= REQ_LANES;
            DATA_LINES_OUT <= REQ_WDATA;
          end
        end
        ST_WSET: begin
          CHIP_SEL_N      <= 1'b0;
          LOW_LANE_SEL_N  <= ~lanes_ff[0];
          HIGH_LANE_SEL_N <= ~lanes_ff[1];
          WRITE_N         <= 1'b0;
          OUT_EN_N        <= 1'b1;
          // data goes out with the strobe; the whole pulse is its set-up time
          DATA_LINES_OE   <= 1'b1;
        end
        ST_WPUL: begin
          if (cnt_done) begin
            WRITE_N <= 1'b1;
          end
        end
        ST_WEND: begin
          // data held one cycle past strobe rise for hold margin
          CHIP_SEL_N      <= 1'b1;
          LOW_LANE_SEL_N  <= 1'b1;
          HIGH_LANE_SEL_N <= 1'b1;
          DATA_LINES_OE   <= 1'b0;
        end
        ST_RSET: begin
          CHIP_SEL_N      <= 1'b0;
          WRITE_N         <= 1'b1;
          // memory drives only with oe low
          OUT_EN_N        <= 1'b0;
          LOW_LANE_SEL_N  <= ~lanes_ff[0];
          HIGH_LANE_SEL_N <= ~lanes_ff[1];
        end
        ST_RACC: begin
          if (cnt_done) begin
            // sampled two cycles after select went low, one cycle past the access time
            RSP_RDATA       <= lane_rdata;
            RSP_VALID       <= 1'b1;
            CHIP_SEL_N      <= 1'b1;
            OUT_EN_N        <= 1'b1;
            LOW_LANE_SEL_N  <= 1'b1;
            HIGH_LANE_SEL_N <= 1'b1;
          end
        end
        default: begin
          // an unknown state parks every pin deselected
          CHIP_SEL_N      <= 1'b1;
          WRITE_N         <= 1'b1;
          OUT_EN_N        <= 1'b1;
          LOW_LANE_SEL_N  <= 1'b1;
          HIGH_LANE_SEL_N <= 1'b1;
          DATA_LINES_OE   <= 1'b0;
        end
      endcase
    end
  end
endmodule // asrc_host

// ### hw/asrc_consts.vh
/*
  Constants for the asynchronous static memory host controller: geometry
  and timing of the memory pins. Assumes a 100 MHz system clock.
*/
`ifndef ASRC_CONSTS_VH
`define ASRC_CONSTS_VH

`define ASRC_ADDR_W        18
`define ASRC_DATA_W        16
`define ASRC_LANE_W        8
`define ASRC_WORDS         262144
`define ASRC_CLK_PERIOD_NS 10
// write timing in ns
`define ASRC_T_ADDR_WR_NS  8
`define ASRC_T_WP_OEH_NS   8
`define ASRC_T_WP_OEL_NS   10
`define ASRC_T_CS_WR_NS    8
`define ASRC_T_LANE_WR_NS  8
// read access (address access) in ns
`define ASRC_T_ACCESS_NS   10
// least times round up to whole cycles, never below one
`define ASRC_CYC_UP(ns) ((((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS))
`define ASRC_WP_CYC        (`ASRC_CYC_UP(`ASRC_T_WP_OEH_NS))
`define ASRC_ACC_CYC       (`ASRC_CYC_UP(`ASRC_T_ACCESS_NS) + 1)

`endif

// ### hw/asrc_hold_cnt.v
/*
  Down counter that holds a phase of the memory cycle for a number of
  clock cycles. Assumes a synchronous load and one clock.
*/
`timescale 1ns/1ps
module asrc_hold_cnt #(
  parameter W = 4
) (
  input  wire         SYS_CLK,
  input  wire         RESET,
  input  wire         load,
  input  wire [W-1:0] load_val,
  output wire         done
);
  reg [W-1:0] cnt_ff;
  reg [W-1:0] nxt_cnt;

  always @* begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = load_val;
    end else if (cnt_ff != {W{1'b0}}) begin
      nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      cnt_ff <= {W{1'b0}};
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign done = (cnt_ff == {W{1'b0}});
endmodule // asrc_hold_cnt

// ### tb/asrc_host_checker.sv
/* pin checks for the static memory host controller.
   assumes a bind to asrc_host and one clock domain. */
`timescale 1ns/1ps
module asrc_host_checker #(parameter ADDR_W = 18) (
  input wire              SYS_CLK,
  input wire              RESET,
  input wire              REQ_VALID,
  input wire              REQ_WRITE,
  input wire              REQ_READY,
  input wire              RSP_VALID,
  input wire [ADDR_W-1:0] WORD_ADDR,
  input wire              CHIP_SEL_N,
  input wire              WRITE_N,
  input wire              OUT_EN_N,
  input wire              LOW_LANE_SEL_N,
  input wire              HIGH_LANE_SEL_N,
  input wire              DATA_LINES_OE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  sequence take_wr; REQ_VALID && REQ_READY && REQ_WRITE; endsequence
  sequence take_rd; REQ_VALID && REQ_READY && !REQ_WRITE; endsequence
  sequence wr_pulse; !WRITE_N && !CHIP_SEL_N ##1 WRITE_N && !CHIP_SEL_N ##1 CHIP_SEL_N; endsequence
  sequence rd_win;
    (!OUT_EN_N && !CHIP_SEL_N && WRITE_N) [*2] ##1 (RSP_VALID && CHIP_SEL_N);
  endsequence
  a_write_walk:
    assert property (take_wr |-> ##2 wr_pulse) else $error("write pin walk wrong");
  a_read_walk:
    assert property (take_rd |-> ##2 rd_win) else $error("read pin walk wrong");
  a_take_busy:
    assert property (REQ_VALID && REQ_READY |=> !REQ_READY) else $error("ready after take");
  a_cs_covers_we:
    assert property (!WRITE_N |-> !CHIP_SEL_N && OUT_EN_N) else $error("strobe outside select");
  a_lane_in_write:
    assert property (!WRITE_N |-> !(LOW_LANE_SEL_N && HIGH_LANE_SEL_N)) else $error("no lane");
  a_addr_steady:
    assert property (!CHIP_SEL_N |-> $stable(WORD_ADDR)) else $error("address moved");
  a_no_fight:
    assert property (DATA_LINES_OE |-> OUT_EN_N) else $error("data line contention");
  a_idle_float:
    assert property (CHIP_SEL_N |-> !DATA_LINES_OE) else $error("driving while idle");
endmodule // asrc_host_checker

// ### tb/asrc_mem_model.sv
/* behavioural 256K x 16 static memory.
   assumes the bench resolves the data wire from the host enable. */
`timescale 1ns/1ps
module asrc_mem_model #(parameter ACC_NS = 8) (
  input  wire [17:0] word_addr,
  input  wire        chip_sel_n,
  input  wire        write_n,
  input  wire        out_en_n,
  input  wire        low_lane_sel_n,
  input  wire        high_lane_sel_n,
  input  wire [15:0] din,
  output wire [15:0] dout
);
  reg  [15:0] mem [0:262143];
  wire        wr_on = !chip_sel_n && !write_n;
  wire        rd    = !chip_sel_n && write_n && !out_en_n;
  wire [15:0] w     = mem[word_addr];
  // commit selected lanes at end of overlap
  always @(negedge wr_on) begin
    if (!low_lane_sel_n) mem[word_addr][7:0] = din[7:0];
    if (!high_lane_sel_n) mem[word_addr][15:8] = din[15:8];
  end
  // floating lanes show inverted junk, not stale data
  assign #(ACC_NS) dout = {rd && !high_lane_sel_n ? w[15:8] : ~w[15:8],
                           rd && !low_lane_sel_n ? w[7:0] : ~w[7:0]};
endmodule // asrc_mem_model

// ### tb/tb_asrc_host.sv
/* self-checking bench for asrc_host with a memory model.
   assumes the design ports as declared; the bench resolves the data wire. */
`timescale 1ns/1ps
module tb_asrc_host;
  reg         SYS_CLK = 0, RESET = 1, REQ_VALID = 0, REQ_WRITE = 0;
  reg  [17:0] REQ_ADDR = 0;
  reg  [15:0] REQ_WDATA = 0;
  reg  [1:0]  REQ_LANES = 0;
  wire        REQ_READY, RSP_VALID, CHIP_SEL_N, WRITE_N, OUT_EN_N, DATA_LINES_OE;
  wire        LOW_LANE_SEL_N, HIGH_LANE_SEL_N;
  wire [15:0] RSP_RDATA, DATA_LINES_IN, DATA_LINES_OUT;
  wire [17:0] WORD_ADDR;
  integer     failures = 0, cmp_count = 0;
  always #5 SYS_CLK = ~SYS_CLK;
  asrc_host asrc_host_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .REQ_VALID(REQ_VALID),
    .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_LANES(REQ_LANES),
    .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .WORD_ADDR(WORD_ADDR),
    .CHIP_SEL_N(CHIP_SEL_N), .WRITE_N(WRITE_N), .OUT_EN_N(OUT_EN_N),
    .LOW_LANE_SEL_N(LOW_LANE_SEL_N), .HIGH_LANE_SEL_N(HIGH_LANE_SEL_N),
    .DATA_LINES_IN(DATA_LINES_IN), .DATA_LINES_OUT(DATA_LINES_OUT),
    .DATA_LINES_OE(DATA_LINES_OE));
  asrc_mem_model #(.ACC_NS(8)) asrc_mem_model_inst (.word_addr(WORD_ADDR),
    .chip_sel_n(CHIP_SEL_N), .write_n(WRITE_N), .out_en_n(OUT_EN_N),
    .low_lane_sel_n(LOW_LANE_SEL_N), .high_lane_sel_n(HIGH_LANE_SEL_N),
    .din(DATA_LINES_OE ? DATA_LINES_OUT : ~DATA_LINES_OUT), .dout(DATA_LINES_IN));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task req(input w, input [17:0] a, input [15:0] d, input [1:0] l);
    begin
      @(posedge SYS_CLK);
      REQ_VALID <= 1'b1;
      REQ_WRITE <= w;
      REQ_ADDR  <= a;
      REQ_WDATA <= d;
      REQ_LANES <= l;
      do @(posedge SYS_CLK); while (REQ_READY !== 1'b1);
      REQ_VALID <= 1'b0;
    end
  endtask
  task rd(input [17:0] a, input [1:0] l, input [15:0] exp);
    begin
      req(1'b0, a, 16'h0000, l);
      do @(posedge SYS_CLK); while (RSP_VALID !== 1'b1);
      chk(RSP_RDATA, exp);
    end
  endtask
  task t_idle;
    begin
      @(posedge SYS_CLK);
      chk({10'h000, CHIP_SEL_N, WRITE_N, OUT_EN_N, LOW_LANE_SEL_N, HIGH_LANE_SEL_N,
           DATA_LINES_OE}, 16'h003E);
      $display("idle test done");
    end
  endtask
  task t_word;
    begin
      req(1'b1, 18'h00000, 16'h1234, 2'h3);
      req(1'b1, 18'h3FFFF, 16'hBEEF, 2'h3);
      rd(18'h00000, 2'h3, 16'h1234);
      rd(18'h3FFFF, 2'h3, 16'hBEEF);
      $display("word test done");
    end
  endtask
  task t_lanes;
    begin
      req(1'b1, 18'h00005, 16'hFFFF, 2'h3);
      req(1'b1, 18'h00005, 16'h11A5, 2'h1);
      rd(18'h00005, 2'h3, 16'hFFA5);
      rd(18'h00005, 2'h1, 16'h00A5);
      req(1'b1, 18'h00005, 16'h5A22, 2'h2);
      rd(18'h00005, 2'h2, 16'h5A00);
      rd(18'h00005, 2'h3, 16'h5AA5);
      $display("lane test done");
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge SYS_CLK);
    RESET <= 1'b0;
    t_idle;
    t_word;
    t_lanes;
    t_idle;
    finish_test;
  end
  // whole run is some 60 cycles; this bound cuts a hang
  initial begin
    #20000;
    failures = failures + 1;
    finish_test;
  end
endmodule // tb_asrc_host
bind asrc_host asrc_host_checker #(.ADDR_W(ADDR_W)) asrc_host_checker_inst (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
  .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .WORD_ADDR(WORD_ADDR),
  .CHIP_SEL_N(CHIP_SEL_N), .WRITE_N(WRITE_N), .OUT_EN_N(OUT_EN_N),
  .LOW_LANE_SEL_N(LOW_LANE_SEL_N), .HIGH_LANE_SEL_N(HIGH_LANE_SEL_N),
  .DATA_LINES_OE(DATA_LINES_OE));
